// >>> hw/supply_alert_pkg.sv
// Package with register offsets, field layouts and reset values of the supply alert bank.
package supply_alert_pkg;
	localparam logic [7:0]  supply_fault_flags_addr = 8'h5b;
	localparam logic [7:0]  alert_pin_mask_addr     = 8'h5f;
	localparam logic [15:0] supply_fault_reset      = 16'h0000;
	localparam logic [15:0] alert_pin_mask_reset    = 16'h0000;
	localparam logic [15:0] supply_fault_valid      = 16'h007f;
	localparam logic [15:0] alert_pin_mask_valid    = 16'h7ffc;
	localparam int          positive_rail_low_bit   = 0;
	localparam int          negative_rail_high_bit  = 1;
	localparam int          logic_core_low_bit      = 2;
	localparam int          analog_core_low_bit     = 3;
	localparam int          regulator_out_low_bit   = 4;
	localparam int          output_supply_low_bit   = 5;
	localparam int          cal_memory_fault_bit    = 6;
	localparam int          num_supply_flags        = 7;

	// Supply monitor comparator indications, one bit each, high while the fault is present.
	typedef struct packed {
		logic output_supply_low;
		logic regulator_out_low;
		logic analog_core_supply_low;
		logic logic_core_supply_low;
		logic negative_rail_high;
		logic positive_rail_low;
	} supply_monitor_s;

	// One register access from the serial port front end.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_access_s;
endpackage : supply_alert_pkg

// >>> hw/fault_sync.sv
// Two-flop synchroniser for asynchronous fault indications.
`timescale 1ns/1ps
`default_nettype none
module fault_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk, // Register clock.
	input  wire logic             sys_rst,  // Synchronous reset, active high.
	input  wire logic             clk_en,   // Freezes state while low.
	input  wire logic [WIDTH-1:0] async_in, // Level from outside the clock domain.
	output logic      [WIDTH-1:0] sync_out  // Synchronised level.
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = clk_en ? async_in : meta_q;
		sync_d = clk_en ? meta_q : sync_q;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule : fault_sync
`default_nettype wire

// >>> hw/supply_alert_regs.sv
// Latched supply fault flags, alert pin mask and alert output logic.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Supply fault flags stay set; host write of one clears once fault gone.
// - Calibration checksum or uncorrectable error on upload sets bit 6.
// - Register access before memory refresh completes also sets bit 6.
// - Output-stage supply below threshold sets bit 5.
// - Regulator output below threshold sets its fault flag.
// - Analog core supply below threshold sets its fault flag.
// - Logic core supply below threshold sets its fault flag.
// - Negative rail above its threshold sets its fault flag.
// - Positive analog rail below threshold sets its fault flag.
// - Mask bit one hides matching status flag from alert pin; zero allows.
// - Masking never stops the status flag itself from being set.
// - Mask bits 14 to 2 read-write; bits 15, 1, 0 reserved.
// - Both registers reset to all zeros.
// - Bits 4 regulator, 3 analog core, 2 logic core, 1 negative, 0 positive.
// - Live summary bit follows supply fault register contents without latching.
module supply_alert_regs (
	input  wire logic                           core_clk,        // Register clock, 250 MHz.
	input  wire logic                           sys_rst,         // Synchronous reset, active high.
	input  wire logic                           clk_en,          // Freezes all state while low.
	input  wire supply_alert_pkg::supply_monitor_s monitor,      // Asynchronous comparator levels.
	input  wire logic                           cal_upload_err,  // Upload checksum or ECC fault pulse.
	input  wire logic                           refresh_done,    // Calibration refresh finished.
	input  wire supply_alert_pkg::reg_access_s  access,          // Register access, one-cycle valid.
	input  wire logic [15:0]                    general_status,  // Latched general status flags.
	output logic      [15:0]                    rdata,           // Read data, registered.
	output logic                                rdata_valid,     // Read data valid pulse.
	output logic      [15:0]                    supply_fault_out,// Supply fault register contents.
	output logic                                supply_summary,  // Live summary of supply flags.
	output logic                                alert_active     // Alert pin request, active high.
);
	logic [5:0]  mon_sync;
	logic [15:0] flags_q;
	logic [15:0] flags_d;
	logic [15:0] mask_q;
	logic [15:0] mask_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [15:0] fault_now;
	logic        wr_flags;
	logic        wr_mask;
	logic        early_access;

	// Comparators sit on their own supplies, so their levels are resynchronised.
	fault_sync #(
		.WIDTH(6)
	) u_mon_sync (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.async_in(monitor),
		.sync_out(mon_sync)
	);

	assign early_access = access.valid && !refresh_done;
	assign wr_flags = access.valid && access.write && refresh_done
		&& (access.addr == supply_alert_pkg::supply_fault_flags_addr);
	assign wr_mask = access.valid && access.write && refresh_done
		&& (access.addr == supply_alert_pkg::alert_pin_mask_addr);

	always_comb begin
		fault_now = '0;
		fault_now[5:0] = mon_sync;
		fault_now[supply_alert_pkg::cal_memory_fault_bit] = cal_upload_err || early_access;
	end

	// Setting wins over a same-cycle clear, so a still-present fault survives a clear.
	always_comb begin
		flags_d = flags_q;
		mask_d  = mask_q;
		if (wr_flags) begin
			flags_d = flags_q & ~access.wdata;
		end
		flags_d = (flags_d | fault_now) & supply_alert_pkg::supply_fault_valid;
		if (wr_mask) begin
			mask_d = access.wdata & supply_alert_pkg::alert_pin_mask_valid;
		end
	end

	// Reads made before the refresh completes return zero and only raise the fault.
	always_comb begin
		rvalid_d = access.valid && !access.write;
		rdata_d  = '0;
		if (access.valid && !access.write && refresh_done) begin
			unique case (access.addr)
				supply_alert_pkg::supply_fault_flags_addr: rdata_d = flags_q;
				supply_alert_pkg::alert_pin_mask_addr:     rdata_d = mask_q;
				default:                                   rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags_q  <= supply_alert_pkg::supply_fault_reset;
			mask_q   <= supply_alert_pkg::alert_pin_mask_reset;
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else if (clk_en) begin
			flags_q  <= flags_d;
			mask_q   <= mask_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign rdata            = rdata_q;
	assign rdata_valid      = rvalid_q && clk_en;
	assign supply_fault_out = flags_q;
	assign supply_summary   = |flags_q;
	// The mask only gates the pin; general_status itself is untouched here.
	assign alert_active = |(general_status & ~mask_q
		& supply_alert_pkg::alert_pin_mask_valid);
endmodule : supply_alert_regs
`default_nettype wire

// >>> tb/supply_alert_props.sv
// Port assertions for the supply alert register bank.
`timescale 1ns/1ps
`default_nettype none
module supply_alert_props (
	input wire logic                              core_clk,         // Clock.
	input wire logic                              sys_rst,          // Reset.
	input wire logic                              clk_en,           // Run enable.
	input wire supply_alert_pkg::supply_monitor_s monitor,          // Comparators.
	input wire logic                              cal_upload_err,   // Upload fault.
	input wire logic                              refresh_done,     // Refresh over.
	input wire supply_alert_pkg::reg_access_s     access,           // Request.
	input wire logic [15:0]                       general_status,   // Status flags.
	input wire logic                              rdata_valid,      // Read answer.
	input wire logic [15:0]                       supply_fault_out, // Flags.
	input wire logic                              supply_summary,   // Summary.
	input wire logic                              alert_active      // Alert.
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_low_held;
		(monitor.output_supply_low && clk_en)[*4];
	endsequence
	a_alert_cause: assert property (alert_active |-> |general_status[14:2]) else $error("alert without flag");
	a_summary_live: assert property (supply_summary == |supply_fault_out) else $error("summary wrong");
	a_reserved_zero: assert property (supply_fault_out[15:7] == 9'h000) else $error("reserved set");
	a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> supply_fault_out == 16'h0000) else $error("no reset");
	a_read_answer: assert property (clk_en && access.valid && !access.write |=> rdata_valid) else $error("no answer");
	a_cal_sets: assert property (clk_en && cal_upload_err |=> supply_fault_out[6]) else $error("cal flag");
	a_early_access: assert property (clk_en && access.valid && !refresh_done |=> supply_fault_out[6]) else $error("early");
	a_flag_sticky: assert property (clk_en && !(access.valid && access.write) |=> (supply_fault_out & $past(supply_fault_out)) == $past(supply_fault_out)) else $error("flag lost");
	a_monitor_sets: assert property (s_low_held |-> supply_fault_out[5]) else $error("supply flag");
endmodule : supply_alert_props
bind supply_alert_regs supply_alert_props u_props (.core_clk, .sys_rst, .clk_en, .monitor, .cal_upload_err,
	.refresh_done, .access, .general_status, .rdata_valid, .supply_fault_out, .supply_summary, .alert_active);
`default_nettype wire

// >>> tb/tb_supply_alert_regs.sv
// Self-checking testbench of the supply alert register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_supply_alert_regs;
	logic                              core_clk = 1'b0;
	logic                              sys_rst = 1'b1;
	logic                              clk_en = 1'b1;
	logic                              cal_upload_err = 1'b0;
	logic                              refresh_done = 1'b0;
	logic [15:0]                       general_status = 16'h0000;
	logic [15:0]                       rdata;
	logic [15:0]                       fault;
	logic                              rdata_valid;
	logic                              summary;
	logic                              alert;
	supply_alert_pkg::supply_monitor_s monitor = '0;
	supply_alert_pkg::reg_access_s     access = '0;
	int n_mismatch = 0, n_checks = 0, cyc = 0, seed = 20458, mask = 0, i;
	always #2 core_clk = ~core_clk;
	supply_alert_regs u_supply_alert_regs (.core_clk, .sys_rst, .clk_en, .monitor, .cal_upload_err,
		.refresh_done, .access, .general_status, .rdata, .rdata_valid, .supply_fault_out(fault),
		.supply_summary(summary), .alert_active(alert));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk) access <= {1'b1, w, a, d};
		@(posedge core_clk) access <= '0;
		#1;
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		chk("rdata", e, rdata);
		chk("rdata_valid", 16'h0001, {15'h0000, rdata_valid});
	endtask : rd
	task automatic results;
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// A hang in a handshake ends the run as a failure.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			results;
		end
	end
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'h5b, 16'h0000);
		@(posedge core_clk) refresh_done <= 1'b1;
		rd(8'h5b, 16'h0040);
		rd(8'h5f, 16'h0000);
		acc(1'b1, 8'h5b, 16'hffff);
		rd(8'h5b, 16'h0000);
		for (i = 0; i < 6; i++) begin
			@(posedge core_clk) monitor <= 6'(1 << i);
			repeat (4) @(posedge core_clk);
			acc(1'b1, 8'h5b, 16'hffff);
			rd(8'h5b, 16'(1 << i));
			chk("summary", 16'h0001, {15'h0000, summary});
			@(posedge core_clk) monitor <= '0;
			repeat (3) @(posedge core_clk);
			acc(1'b1, 8'h5b, 16'hffff);
			rd(8'h5b, 16'h0000);
		end
		@(posedge core_clk) cal_upload_err <= 1'b1;
		@(posedge core_clk) cal_upload_err <= 1'b0;
		rd(8'h5b, 16'h0040);
		// The host answers a calibration fault with a reset, which must clear every flag.
		@(posedge core_clk) sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'h5b, 16'h0000);
		chk("summary", 16'h0000, {15'h0000, summary});
		// A fault pulse while the clock enable is low must leave the flags frozen.
		@(posedge core_clk) begin
			clk_en <= 1'b0;
			cal_upload_err <= 1'b1;
		end
		repeat (2) @(posedge core_clk);
		clk_en <= 1'b1;
		cal_upload_err <= 1'b0;
		rd(8'h5b, 16'h0000);
		for (i = 0; i < 20; i++) begin
			mask = $random(seed);
			acc(1'b1, 8'h5f, mask[15:0]);
			mask &= 32'h00007ffc;
			rd(8'h5f, mask[15:0]);
			@(posedge core_clk) general_status <= 16'($random(seed));
			#1;
			chk("alert", {15'h0000, |(general_status & ~mask[15:0] & 16'h7ffc)}, {15'h0000, alert});
		end
		rd(8'h40, 16'h0000);
		results;
	end
endmodule : tb_supply_alert_regs
`default_nettype wire
